// [verilog/core_timing_regs.vh]
// Purpose: constants for the core cycle timing and status block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: offsets are byte addresses
// What this block does
// - four states make every machine cycle
// - at most one opcode fetch per machine cycle, only in the first byte-count cycles
// - jumps and calls add one cycle
// - 128 of 256 opcodes single cycle
// - other non-move codes take two, three, four or five cycles
// - data moves stretch two to nine cycles
// - the rising clock edge times internal states, the falling edge the half-state phase
// - carry set on alu carry, bit accumulator
// - aux carry set on nibble carry
// - overflow on carry seven xor eight
// - parity follows accumulator ones count
// - two free user flags
// - bank bits select register bank base
// - suppress bit blocks latch strobe on-chip
// - enable routes data moves to on-chip ram
`ifndef CORE_TIMING_REGS_VH
`define CORE_TIMING_REGS_VH
`define OFS_STATUS 8'h00
`define OFS_CONTROL 8'h04
`define OFS_INSTR 8'h08
`define OFS_STATE 8'h0c
`define OFS_ACC 8'h10
`define BIT_CARRY 7
`define BIT_AUX 6
`define BIT_USERA 5
`define BIT_BANKH 4
`define BIT_BANKL 3
`define BIT_OVF 2
`define BIT_USERB 1
`define BIT_PARITY 0
`define CTL_SUPPRESS 0
`define CTL_XRAM 1
`define CTL_STRETCH_LO 2
`define STATUS_RESET 8'h00
`define STRETCH_RESET 3'h0
`define STATES_PER_CYCLE 2'h3
`define MIN_MOVE_CYCLES 4'h2
`endif

// [verilog/state_sequencer.v]
// Purpose: four-state machine cycle sequencer
// Assumes: runs on both clock edges
// Notes: half-state phase kept on the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "core_timing_regs.vh"
module state_sequencer (
  input wire clk,
  input wire rstn,
  output reg [1:0] state_ff,
  output reg cycleEnd_ff,
  output reg fallPhase_ff
);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= 2'h0;
      cycleEnd_ff <= 1'b0;
    end else begin
      state_ff <= state_ff + 2'h1;
      cycleEnd_ff <= (state_ff == (`STATES_PER_CYCLE - 2'h1));
    end
  end
  // falling edge marks the second half of each state
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      fallPhase_ff <= 1'b0;
    end else begin
      fallPhase_ff <= ~fallPhase_ff;
    end
  end
endmodule // state_sequencer
`default_nettype wire

// [verilog/core_cycle_timing_and_status.v]
// Purpose: instruction cycle timing and program status for an 8-bit core
// Assumes: registers over AHB-Lite, instructions posted by software
// Notes: writes to instr register while none is pending start an instruction with its flag results
`timescale 1ns/1ps
`default_nettype none
`include "core_timing_regs.vh"
module core_cycle_timing_and_status (
  input wire clk,
  input wire rstn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg stateOne_ff,
  output reg stateFour_ff,
  output reg fetchStrobe_ff,
  output reg latchStrobe_ff,
  output reg readStrobe_ff,
  output reg writeStrobe_ff,
  output reg xramSelect_ff,
  output reg busy_ff,
  output reg [4:0] bankBase_ff
);
  ////////////////////////////////////////////////////////////////////////
  reg rs1_ff, rs2_ff;
  wire rst;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end
  assign rst = rs2_ff;
  wire [1:0] state;
  wire cycleEnd;
  state_sequencer seq (
    .clk(clk),
    .rstn(rst),
    .state_ff(state),
    .cycleEnd_ff(cycleEnd),
    .fallPhase_ff()
  );
  ////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_WAIT = 3'b100;
  reg [2:0] fsm_ff, nxt_fsm;
  reg [7:0] status_ff, nxt_status;
  reg [7:0] acc_ff, nxt_acc;
  reg suppress_ff, xramEn_ff;
  reg [2:0] stretch_ff;
  reg [31:0] instr_ff;
  reg pending_ff;
  reg [3:0] cycLeft_ff, nxt_cycLeft;
  reg [3:0] cycCount_ff;
  // instr word: [7:0] opcode, [9:8] bytes-1, [10] jump/call, [11] data move,
  // [12] write, [13] onchip access, [14] carry, [15] aux, [16] ovf en,
  // [17] carry7, [18] carry8, [26:19] acc result, [27] flag update
  reg [31:0] ap_addr_ff;
  reg ap_wr_ff, ap_valid_ff;
  wire apTake = hsel & hready & htrans[1];
  always @(posedge clk or negedge rst) begin
    if (!rst) begin
      ap_addr_ff <= 32'h0;
      ap_wr_ff <= 1'b0;
      ap_valid_ff <= 1'b0;
    end else begin
      ap_valid_ff <= apTake;
      if (apTake) begin
        ap_addr_ff <= haddr;
        ap_wr_ff <= hwrite;
      end
    end
  end
  wire wrPhase = ap_valid_ff & ap_wr_ff;
  wire wrStatus = wrPhase & (ap_addr_ff[7:0] == `OFS_STATUS);
  wire wrControl = wrPhase & (ap_addr_ff[7:0] == `OFS_CONTROL);
  wire wrInstr = wrPhase & (ap_addr_ff[7:0] == `OFS_INSTR) & ~pending_ff;
  wire wrAcc = wrPhase & (ap_addr_ff[7:0] == `OFS_ACC);
  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h0;
    if (haddr[7:0] == `OFS_STATUS) begin
      rdMux = {24'h0, status_ff};
    end else if (haddr[7:0] == `OFS_CONTROL) begin
      rdMux = {27'h0, stretch_ff, xramEn_ff, suppress_ff};
    end else if (haddr[7:0] == `OFS_INSTR) begin
      rdMux = instr_ff;
    end else if (haddr[7:0] == `OFS_STATE) begin
      rdMux = {24'h0, cycCount_ff, pending_ff, busy_ff, state};
    end else if (haddr[7:0] == `OFS_ACC) begin
      rdMux = {24'h0, acc_ff};
    end
  end
  always @(posedge clk or negedge rst) begin
    if (!rst) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (apTake & ~hwrite) begin
        hrdata <= rdMux;
      end
    end
  end
  always @(posedge clk or negedge rst) begin
    if (!rst) begin
      suppress_ff <= 1'b0;
      xramEn_ff <= 1'b0;
      stretch_ff <= `STRETCH_RESET;
    end else if (wrControl) begin
      suppress_ff <= hwdata[`CTL_SUPPRESS];
      xramEn_ff <= hwdata[`CTL_XRAM];
      stretch_ff <= hwdata[`CTL_STRETCH_LO+2:`CTL_STRETCH_LO];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // cycle count of the posted instruction
  wire [3:0] byteCnt = {2'h0, instr_ff[9:8]} + 4'h1;
  wire isMove = instr_ff[11];
  wire [3:0] moveCyc = `MIN_MOVE_CYCLES + {1'b0, stretch_ff};
  wire [3:0] baseCyc = isMove ? moveCyc : byteCnt;
  wire [3:0] totalCyc = baseCyc + {3'h0, instr_ff[10] & ~isMove};
  // single-cycle for one byte non-jump non-move codes, otherwise 2..5 or stretched
  wire [3:0] clipCyc = (totalCyc > 4'h5 && !isMove) ? 4'h5 : totalCyc;
  wire lastCycle = (cycLeft_ff == 4'h1) & cycleEnd;
  always @* begin
    nxt_fsm = fsm_ff;
    nxt_cycLeft = cycLeft_ff;
    case (fsm_ff)
      ST_IDLE: begin
        if (pending_ff) begin
          nxt_fsm = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cycleEnd) begin
          nxt_fsm = ST_RUN;
          nxt_cycLeft = clipCyc;
        end
      end
      ST_RUN: begin
        if (cycleEnd) begin
          nxt_cycLeft = cycLeft_ff - 4'h1;
          if (cycLeft_ff == 4'h1) begin
            nxt_fsm = ST_IDLE;
          end
        end
      end
      default: nxt_fsm = ST_IDLE;
    endcase
  end
  wire running = (fsm_ff == ST_RUN);
  wire doneNow = running & lastCycle;
  always @(posedge clk or negedge rst) begin
    if (!rst) begin
      fsm_ff <= ST_IDLE;
      cycLeft_ff <= 4'h0;
      cycCount_ff <= 4'h0;
      instr_ff <= 32'h0;
      pending_ff <= 1'b0;
    end else begin
      fsm_ff <= nxt_fsm;
      cycLeft_ff <= nxt_cycLeft;
      if (wrInstr) begin
        instr_ff <= hwdata;
        pending_ff <= 1'b1;
        cycCount_ff <= 4'h0;
      end else if (doneNow) begin
        pending_ff <= 1'b0;
      end
      if (running & cycleEnd) begin
        cycCount_ff <= cycCount_ff + 4'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always @* begin
    nxt_status = status_ff;
    nxt_acc = acc_ff;
    if (wrStatus) begin
      nxt_status = hwdata[7:0];
    end
    if (wrAcc) begin
      nxt_acc = hwdata[7:0];
    end
    if (doneNow & instr_ff[27]) begin
      nxt_status[`BIT_CARRY] = instr_ff[14];
      nxt_status[`BIT_AUX] = instr_ff[15];
      if (instr_ff[16]) begin
        nxt_status[`BIT_OVF] = instr_ff[17] ^ instr_ff[18];
      end
      nxt_acc = instr_ff[26:19];
    end
    nxt_status[`BIT_PARITY] = ^nxt_acc;
  end
  always @(posedge clk or negedge rst) begin
    if (!rst) begin
      status_ff <= `STATUS_RESET;
      acc_ff <= 8'h00;
    end else begin
      status_ff <= nxt_status;
      acc_ff <= nxt_acc;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  wire moveCycle = running & isMove & (cycLeft_ff != clipCyc);
  wire toXram = xramEn_ff & isMove;
  wire onchip = instr_ff[13] | toXram;
  always @(posedge clk or negedge rst) begin
    if (!rst) begin
      stateOne_ff <= 1'b0;
      stateFour_ff <= 1'b0;
      fetchStrobe_ff <= 1'b0;
      latchStrobe_ff <= 1'b0;
      readStrobe_ff <= 1'b0;
      writeStrobe_ff <= 1'b0;
      xramSelect_ff <= 1'b0;
      busy_ff <= 1'b0;
      bankBase_ff <= 5'h00;
    end else begin
      stateOne_ff <= (state == 2'h3);
      stateFour_ff <= (state == 2'h2);
      fetchStrobe_ff <= running & (state == 2'h3) & (cycLeft_ff > (clipCyc - byteCnt));
      latchStrobe_ff <= running & (state == 2'h3) & ~(suppress_ff & onchip);
      readStrobe_ff <= moveCycle & ~instr_ff[12] & ~toXram;
      writeStrobe_ff <= moveCycle & instr_ff[12] & ~toXram;
      xramSelect_ff <= moveCycle & toXram;
      busy_ff <= pending_ff;
      bankBase_ff <= {status_ff[`BIT_BANKH], status_ff[`BIT_BANKL], 3'h0};
    end
  end
endmodule // core_cycle_timing_and_status
`default_nettype wire

// [test/core_timing_properties.sv]
// Purpose: port checks for core timing
// Assumes: bound to the top module
// Notes: one clock domain
`timescale 1ns/1ps
`default_nettype none
module core_timing_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stateOne_ff,
  input wire logic stateFour_ff,
  input wire logic fetchStrobe_ff,
  input wire logic latchStrobe_ff,
  input wire logic readStrobe_ff,
  input wire logic writeStrobe_ff,
  input wire logic xramSelect_ff,
  input wire logic [4:0] bankBase_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  //////////////////////////////
  property p_s4; stateOne_ff |-> ##3 stateFour_ff; endproperty
  a_s4: assert property (p_s4) else $error("s4");
  property p_s1; stateFour_ff |=> stateOne_ff; endproperty
  a_s1: assert property (p_s1) else $error("s1");
  property p_gap; stateOne_ff |=> !stateOne_ff [*3]; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_fe; fetchStrobe_ff |-> stateOne_ff ##1 !fetchStrobe_ff [*3]; endproperty
  a_fe: assert property (p_fe) else $error("fe");
  property p_la; latchStrobe_ff |-> stateOne_ff; endproperty
  a_la: assert property (p_la) else $error("la");
  property p_rw; !(readStrobe_ff && writeStrobe_ff); endproperty
  a_rw: assert property (p_rw) else $error("rw");
  property p_xr; xramSelect_ff |-> !readStrobe_ff && !writeStrobe_ff; endproperty
  a_xr: assert property (p_xr) else $error("xr");
  property p_bk; bankBase_ff[2:0] == 3'h0; endproperty
  a_bk: assert property (p_bk) else $error("bk");
  cover property (fetchStrobe_ff);
  cover property (readStrobe_ff);
  cover property (xramSelect_ff);
endmodule // core_timing_properties
`default_nettype wire

// [test/strobe_partner.sv]
// Purpose: far-side memory model timing the strobes
// Assumes: strobe levels sampled on the rising edge
// Notes: counts clear on reset
`timescale 1ns/1ps
`default_nettype none
module strobe_partner (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rdS,
  input wire logic wrS,
  input wire logic laS,
  input wire logic xS,
  output logic [7:0] sLen,
  output logic [7:0] lCnt,
  output logic [7:0] xCnt
);
  logic [7:0] cnt;
  //////////////////////////////
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 8'h0;
      sLen <= 8'h0;
      lCnt <= 8'h0;
      xCnt <= 8'h0;
    end else begin
      cnt <= (rdS | wrS) ? cnt + 8'h1 : 8'h0;
      if (!(rdS | wrS) && cnt != 8'h0) sLen <= cnt;
      lCnt <= lCnt + {7'h0, laS};
      xCnt <= xCnt + {7'h0, xS};
    end
  end
endmodule // strobe_partner
`default_nettype wire

// [test/core_cycle_timing_and_status_tb_top.sv]
// Purpose: bench for core timing and status
// Assumes: zero-wait AHB-Lite slave
// Notes: partner times the strobes
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin errorCnt++; $display("Error %0t %h %h", $time, a, e); end end
module core_cycle_timing_and_status_tb_top;
  logic clk = 0, rstn = 0, hsel = 0, hw = 0;
  logic [1:0] ht = 0;
  logic [31:0] ha = 0, wd = 0, rd;
  logic [7:0] n0;
  wire [31:0] hr;
  wire rdy, rs, ws, la, xs, resp, busy;
  wire [4:0] bank;
  wire [7:0] sLen, lCnt, xCnt;
  int errorCnt = 0, numChecks = 0, cyc = 0, k, t;
  always #5 clk = ~clk;
  core_cycle_timing_and_status uut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(ha), .htrans(ht), .hwrite(hw),
    .hsize(3'h2), .hwdata(wd), .hready(rdy), .hrdata(hr), .hreadyout(rdy), .hresp(resp), .stateOne_ff(),
    .stateFour_ff(), .fetchStrobe_ff(), .latchStrobe_ff(la), .readStrobe_ff(rs), .writeStrobe_ff(ws),
    .xramSelect_ff(xs), .busy_ff(busy), .bankBase_ff(bank));
  strobe_partner ext (.clk(clk), .rstn(rstn), .rdS(rs), .wrS(ws), .laS(la), .xS(xs), .sLen(sLen),
    .lCnt(lCnt), .xCnt(xCnt));
  //////////////////////////////
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    ha <= {24'h0, a};
    ht <= 2'h2;
    hw <= w;
    hsel <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    ht <= 2'h0;
    wd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hr;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(resp, 1'b0)
  endtask
  task automatic run(input logic [31:0] ins, input logic [3:0] c);
    xf(1'b1, 8'h08, ins);
    t = 0;
    do begin
      xf(1'b0, 8'h0c, 32'h0);
      t++;
    end while (rd[3:2] !== 2'b00 && t < 300);
    if (t >= 300) errorCnt++;
    `CHK(rd[7:4], c)
    `CHK(busy, 1'b0)
  endtask
  task automatic giveVerdict();
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errorCnt++;
      giveVerdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(8'h00, 32'h0);
    chk(8'h04, 32'h0);
    for (k = 0; k < 4; k++) begin
      xf(1'b1, 8'h00, k << 3);
      repeat (2) @(posedge clk);
      `CHK(bank, 5'(k * 8))
    end
    xf(1'b1, 8'h00, 32'h23);
    chk(8'h00, 32'h22);
    xf(1'b1, 8'h10, 32'h07);
    chk(8'h00, 32'h23);
    xf(1'b1, 8'h00, 32'h0);
    run(32'h081bc000, 4'h1);
    chk(8'h00, 32'hc4);
    for (k = 0; k < 8; k++) begin
      run({21'h0, k[0], k[2:1], 8'h00}, 4'(k / 2 + k % 2 + 1));
    end
    xf(1'b1, 8'h04, 32'h1c);
    run(32'h0800, 4'h9);
    `CHK(sLen, 8'd32)
    xf(1'b1, 8'h04, 32'h0);
    run(32'h1800, 4'h2);
    `CHK(sLen, 8'd4)
    xf(1'b1, 8'h04, 32'h3);
    n0 = lCnt;
    run(32'h2800, 4'h2);
    `CHK(lCnt, n0)
    `CHK(xCnt, 8'd4)
    xf(1'b1, 8'h04, 32'h1);
    run(32'h0800, 4'h2);
    `CHK(lCnt, n0 + 8'd2)
    giveVerdict();
  end
endmodule // core_cycle_timing_and_status_tb_top
bind core_cycle_timing_and_status core_timing_properties chk_i (.clk(clk), .rstn(rstn), .stateOne_ff(stateOne_ff),
  .stateFour_ff(stateFour_ff), .fetchStrobe_ff(fetchStrobe_ff), .latchStrobe_ff(latchStrobe_ff),
  .readStrobe_ff(readStrobe_ff), .writeStrobe_ff(writeStrobe_ff), .xramSelect_ff(xramSelect_ff),
  .bankBase_ff(bankBase_ff));
`default_nettype wire
